// >>> mal_alarm_top.sv
// Alarm flag latching, masking and alarm pin with an AHB-Lite register slave.
//
// Local design decision: the AHB-Lite slave port.
module mal_alarm_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic sample_tick,
  input wire logic [12:0] ev_cond,
  output logic alarm_out_b
);

  // Bus state.
  mal_pkg::mal_bus_st_t st_ff;
  mal_pkg::mal_bus_st_t nxt_st;
  logic hreadyout_ff;
  logic hresp_ff;
  logic [31:0] hrdata_ff;
  logic wr_ff;
  logic sel_cfg_ff;
  logic sel_ctrl_ff;
  logic sel_stat_ff;
  logic sel_mon_ff;

  // Registers.
  logic [15:0] ctrl_ff;
  logic [1:0] deb_ff;
  logic pin_on_ff;
  logic lt_on_ff;
  logic soft_ff;
  logic [12:0] flag_ff;
  logic [12:0] nxt_flag;
  logic alarm_b_ff;
  logic nxt_alarm_b;

  // Address phase decode.
  logic take;
  logic word;
  logic a_cfg;
  logic a_ctrl;
  logic a_stat;
  logic a_mon;

  assign take = hsel && htrans[1] && hready && st_ff == mal_pkg::ST_ADDR;
  assign word = hsize == mal_pkg::HSIZE_WORD;
  assign a_cfg = word && haddr == mal_pkg::CFG_ADDR;
  assign a_ctrl = word && haddr == mal_pkg::CTRL_ADDR;
  assign a_stat = word && haddr == mal_pkg::STAT_ADDR;
  assign a_mon = word && haddr == mal_pkg::MON_ADDR;

  // Data phase strobes.
  logic in_data;
  logic wr_cfg;
  logic wr_ctrl;
  logic wr_mon;
  logic rd_stat;

  assign in_data = st_ff == mal_pkg::ST_DATA;
  assign wr_cfg = in_data && wr_ff && sel_cfg_ff;
  assign wr_ctrl = in_data && wr_ff && sel_ctrl_ff;
  assign wr_mon = in_data && wr_ff && sel_mon_ff;
  assign rd_stat = in_data && !wr_ff && sel_stat_ff; // RULE_21

  // Read data, unmapped addresses read as zero.
  logic [31:0] rd_cfg;
  logic [31:0] rd_ctrl;
  logic [31:0] rd_stat_w;
  logic [31:0] rd_mon;
  logic [31:0] rd_word;

  assign rd_cfg = {27'h0000000, deb_ff, 3'h0};
  assign rd_ctrl = {16'h0000, ctrl_ff}; // RULE_20
  assign rd_stat_w = {17'h00000, flag_ff, 2'h0};
  assign rd_mon = {30'h00000000, lt_on_ff, pin_on_ff};
  assign rd_word = sel_cfg_ff ? rd_cfg :
                   sel_ctrl_ff ? rd_ctrl :
                   sel_stat_ff ? rd_stat_w :
                   sel_mon_ff ? rd_mon : 32'h00000000;

  // Every transfer takes one wait state so read data leave a flip-flop.
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      mal_pkg::ST_ADDR:
      begin
        if (take)
        begin
          nxt_st = mal_pkg::ST_DATA;
        end
      end
      mal_pkg::ST_DATA:
      begin
        nxt_st = mal_pkg::ST_ADDR;
      end
      default:
      begin
        nxt_st = mal_pkg::ST_ADDR;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff <= mal_pkg::ST_ADDR;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      hreadyout_ff <= !take;
      hresp_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ff <= 1'b0;
      sel_cfg_ff <= 1'b0;
      sel_ctrl_ff <= 1'b0;
      sel_stat_ff <= 1'b0;
      sel_mon_ff <= 1'b0;
    end
    else if (take)
    begin
      wr_ff <= hwrite;
      sel_cfg_ff <= a_cfg;
      sel_ctrl_ff <= a_ctrl;
      sel_stat_ff <= a_stat;
      sel_mon_ff <= a_mon;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hrdata_ff <= 32'h00000000;
    end
    else if (in_data)
    begin
      hrdata_ff <= wr_ff ? 32'h00000000 : rd_word;
    end
  end

  // Alarm control register; reserved bits never store a one.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_ff <= mal_pkg::CTRL_RST; // RULE_20
    end
    else if (wr_ctrl)
    begin
      ctrl_ff <= hwdata[15:0] & mal_pkg::CTRL_WR_MASK; // RULE_20
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      deb_ff <= mal_pkg::DEB_RST; // RULE_01
    end
    else if (wr_cfg)
    begin
      deb_ff <= hwdata[mal_pkg::CFG_DEB_LSB +: 2];
    end
  end

  // The software reset bit is a one-cycle pulse and always reads zero.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_on_ff <= mal_pkg::MON_RST[mal_pkg::MON_PIN_ON];
      lt_on_ff <= mal_pkg::MON_RST[mal_pkg::MON_LT_ON];
      soft_ff <= 1'b0;
    end
    else
    begin
      soft_ff <= wr_mon && hwdata[mal_pkg::MON_SOFT_RST];
      if (wr_mon)
      begin
        pin_on_ff <= hwdata[mal_pkg::MON_PIN_ON];
        lt_on_ff <= hwdata[mal_pkg::MON_LT_ON];
      end
    end
  end

  // Event conditioning: local sensor events only count while it is on.
  logic [12:0] cond_g;
  logic [12:0] lt_gate;
  logic [12:0] qual;
  logic [12:0] hit;
  logic local_temp_sensor_on;

  assign local_temp_sensor_on = lt_on_ff;

  always_comb
  begin
    lt_gate = '1;
    lt_gate[mal_pkg::EV_OVERHEAT] = local_temp_sensor_on; // RULE_24
    lt_gate[mal_pkg::EV_LT_OVER] = local_temp_sensor_on; // RULE_24
    lt_gate[mal_pkg::EV_LT_UNDER] = local_temp_sensor_on; // RULE_24
  end

  assign cond_g = ev_cond & lt_gate;

  // Only the temperature range events use the programmable count.
  genvar gi;
  generate
    for (gi = 0; gi < mal_pkg::NUM_EV; gi++)
    begin : g_deb
      localparam bit TEMP = gi >= mal_pkg::EV_DEB_LO &&
                            gi <= mal_pkg::EV_DEB_HI;
      mal_debounce u_deb (
        .clk(clk),
        .rst_b(rst_b),
        .clr(soft_ff),
        .sample(sample_tick),
        .cond(cond_g[gi]),
        .code(TEMP ? deb_ff : mal_pkg::DEB_CODE_ONE), // RULE_01
        .qual(qual[gi]),
        .hit(hit[gi])
      );
    end
  endgenerate

  // Flags are set regardless of the enable bits.
  logic sticky_off;
  logic [12:0] set_v;
  logic [12:0] keep_v;

  assign sticky_off = ctrl_ff[mal_pkg::CTRL_STICKY_OFF];
  assign set_v = soft_ff ? 13'h0000 : hit; // RULE_02 RULE_05 RULE_16 RULE_17
  // A sample that qualifies in the read cycle wins over the clear.
  assign keep_v = (rd_stat || soft_ff) ? 13'h0000 : flag_ff; // RULE_21

  always_comb
  begin
    if (sticky_off)
    begin
      nxt_flag = soft_ff ? 13'h0000 : qual; // RULE_18
    end
    else
    begin
      nxt_flag = set_v | keep_v; // RULE_19 RULE_22
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flag_ff <= 13'h0000; // RULE_21
    end
    else
    begin
      flag_ff <= nxt_flag;
    end
  end

  // Mask vector: the overheat slot has no control bit at all.
  logic [12:0] en_v;
  logic any_alarm;

  // Control bits 14 down to 3 line up with events 12 down to 1.
  logic [11:0] en_field;
  logic chan_zero_pin_enable;
  logic chan_one_pin_enable;
  logic chan_two_pin_enable;
  logic chan_three_pin_enable;
  logic local_temp_under_pin_enable;
  logic local_temp_over_pin_enable;
  logic remote_one_under_pin_enable;
  logic remote_one_over_pin_enable;
  logic remote_two_under_pin_enable;
  logic remote_two_over_pin_enable;
  logic remote_one_broken_pin_enable;
  logic remote_two_broken_pin_enable;

  assign en_field = ctrl_ff[mal_pkg::CTRL_EN_MSB:mal_pkg::CTRL_EN_LSB];
  assign chan_zero_pin_enable = en_field[11]; // RULE_06
  assign chan_one_pin_enable = en_field[10]; // RULE_07
  assign chan_two_pin_enable = en_field[9]; // RULE_08
  assign chan_three_pin_enable = en_field[8]; // RULE_09
  assign local_temp_under_pin_enable = en_field[7]; // RULE_10
  assign local_temp_over_pin_enable = en_field[6]; // RULE_11
  assign remote_one_under_pin_enable = en_field[5]; // RULE_12
  assign remote_one_over_pin_enable = en_field[4]; // RULE_13
  assign remote_two_under_pin_enable = en_field[3]; // RULE_14
  assign remote_two_over_pin_enable = en_field[2]; // RULE_15
  assign remote_one_broken_pin_enable = en_field[1]; // RULE_16
  assign remote_two_broken_pin_enable = en_field[0]; // RULE_17

  // The overheat slot is a constant one, so no write can ever mask it.
  assign en_v = {chan_zero_pin_enable,
                 chan_one_pin_enable,
                 chan_two_pin_enable,
                 chan_three_pin_enable,
                 local_temp_under_pin_enable,
                 local_temp_over_pin_enable,
                 remote_one_under_pin_enable,
                 remote_one_over_pin_enable,
                 remote_two_under_pin_enable,
                 remote_two_over_pin_enable,
                 remote_one_broken_pin_enable,
                 remote_two_broken_pin_enable,
                 1'b1}; // RULE_03 RULE_04
  assign any_alarm = |(flag_ff & en_v); // RULE_05 RULE_25
  assign nxt_alarm_b = !(pin_on_ff && any_alarm); // RULE_25

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      alarm_b_ff <= 1'b1;
    end
    else
    begin
      alarm_b_ff <= nxt_alarm_b;
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hrdata = hrdata_ff;
  assign hresp = hresp_ff;
  assign alarm_out_b = alarm_b_ff;

endmodule : mal_alarm_top

// >>> mal_pkg.sv
// Constants, register map and types of the monitor alarm mask and latch.
// Function
// RULE_01 - Temperature flag needs 1, 2, 4 or 8 samples in a row; 4 at reset.
// RULE_02 - Enable bits gate only the alarm pin, never the status flags.
// RULE_03 - Die overheat flag is always enabled onto the alarm pin.
// RULE_04 - Software has no way to mask the die overheat alarm.
// RULE_05 - A masked event still sets its flag but leaves the pin high.
// RULE_06 - Bit 14 enables channel zero, single-ended and zero/one pair.
// RULE_07 - Bit 13 enables the channel one single-ended event.
// RULE_08 - Bit 12 enables channel two, single-ended and two/three pair.
// RULE_09 - Bit 11 enables the channel three single-ended event.
// RULE_10 - Bit 10 enables the local under-temperature event.
// RULE_11 - Bit 9 enables the local over-temperature event.
// RULE_12 - Bit 8 enables the first remote sensor under-range event.
// RULE_13 - Bit 7 enables the first remote sensor over-range event.
// RULE_14 - Bit 6 enables the second remote sensor under-range event.
// RULE_15 - Bit 5 enables the second remote sensor over-range event.
// RULE_16 - Bit 4 enables the first remote sensor failure event.
// RULE_17 - Bit 3 enables the second remote sensor failure event.
// RULE_18 - Bit 2 set makes flags follow their condition, read or not.
// RULE_19 - Bit 2 clear holds each set flag until a status read.
// RULE_20 - Control bits 15, 1, 0 read zero, ignore writes; rest reset zero.
// RULE_21 - Status read, hardware reset or software reset clears all flags.
// RULE_22 - A cleared flag sets again if its condition holds next sample.
// RULE_23 - A flag stays clear if the input recovers before the count.
// RULE_24 - Local temperature flags are checked only while that sensor is on.
// RULE_25 - Alarm pin low is the OR of enabled set flags and overheat.
package mal_pkg;

  // Register indices; the bus byte address is four times the index.
  localparam logic [7:0] CFG_IDX = 8'h4D;
  localparam logic [7:0] CTRL_IDX = 8'h4E;
  localparam logic [7:0] STAT_IDX = 8'h4F;
  localparam logic [7:0] MON_IDX = 8'h50;
  localparam logic [31:0] CFG_ADDR = {22'h000000, CFG_IDX, 2'h0};
  localparam logic [31:0] CTRL_ADDR = {22'h000000, CTRL_IDX, 2'h0};
  localparam logic [31:0] STAT_ADDR = {22'h000000, STAT_IDX, 2'h0};
  localparam logic [31:0] MON_ADDR = {22'h000000, MON_IDX, 2'h0};
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Event vector: event k sits at status bit k + EV_LSB.
  localparam int NUM_EV = 13;
  localparam int EV_LSB = 2;
  localparam int EV_OVERHEAT = 0;
  localparam int EV_LT_OVER = 7;
  localparam int EV_LT_UNDER = 8;
  localparam int EV_DEB_LO = 3;
  localparam int EV_DEB_HI = 8;

  // Alarm control register.
  localparam int CTRL_EN_LSB = 3;
  localparam int CTRL_EN_MSB = 14;
  localparam int CTRL_STICKY_OFF = 2;
  localparam logic [15:0] CTRL_WR_MASK = 16'h7FFC;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  // Configuration register: temperature debounce code.
  localparam int CFG_DEB_LSB = 3;
  localparam logic [1:0] DEB_RST = 2'h2;
  localparam logic [1:0] DEB_CODE_ONE = 2'h0;
  localparam logic [3:0] DEB_N0 = 4'h1;
  localparam logic [3:0] DEB_N1 = 4'h2;
  localparam logic [3:0] DEB_N2 = 4'h4;
  localparam logic [3:0] DEB_N3 = 4'h8;

  // Monitor control register.
  localparam int MON_PIN_ON = 0;
  localparam int MON_LT_ON = 1;
  localparam int MON_SOFT_RST = 2;
  localparam logic [1:0] MON_RST = 2'h3;

  typedef enum logic [1:0] {
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10
  } mal_bus_st_t;

endpackage : mal_pkg

// >>> mal_debounce.sv
// Consecutive-sample qualifier for one alarm event.
module mal_debounce (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic sample,
  input wire logic cond,
  input wire logic [1:0] code,
  output logic qual,
  output logic hit
);

  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [3:0] need;
  logic [3:0] cnt_up;
  logic qual_ff;
  logic nxt_qual;

  assign need = (code == 2'h0) ? mal_pkg::DEB_N0 :
                (code == 2'h1) ? mal_pkg::DEB_N1 :
                (code == 2'h2) ? mal_pkg::DEB_N2 : mal_pkg::DEB_N3; // RULE_01

  // The count saturates so a lowered code still qualifies at once.
  assign cnt_up = (cnt_ff >= need) ? cnt_ff : cnt_ff + 4'h1;
  assign nxt_cnt = clr ? 4'h0 :
                   !sample ? cnt_ff :
                   cond ? cnt_up : 4'h0; // RULE_23
  assign nxt_qual = clr ? 1'b0 :
                    sample ? (cond && cnt_up >= need) : qual_ff; // RULE_01
  assign hit = sample && !clr && cond && cnt_up >= need;
  assign qual = qual_ff;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_ff <= 4'h0;
      qual_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      qual_ff <= nxt_qual;
    end
  end

endmodule : mal_debounce

// >>> mal_host_watch.sv
// Host model that watches the active-low alarm pin.
module mal_host_watch (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic alarm_out_b,
  output logic alarm_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // The host registers the pin once, so it sees the alarm a cycle late.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      alarm_seen <= 1'b0;
    else
      alarm_seen <= !alarm_out_b;
  end
endmodule : mal_host_watch

// >>> mal_alarm_properties.sv
// Port checker for the alarm mask and latch block.
module mal_alarm_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic sample_tick,
  input wire logic [12:0] ev_cond,
  input wire logic alarm_out_b
);
  logic ph_ff, w_ff, c_ff, m_ff, oh_ff;
  logic [11:0] en_ff;
  logic [1:0] mon_ff;
  wire take = hsel && htrans[1] && hready;
  wire done = ph_ff && !hreadyout && w_ff;
  always_ff @(posedge clk)
  begin
    if (take)
    begin
      w_ff <= hwrite;
      c_ff <= haddr == mal_pkg::CTRL_ADDR;
      m_ff <= haddr == mal_pkg::MON_ADDR;
    end
  end
  // Shadow copies of the enables and pin state let the checks know intent.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ph_ff <= 1'b0;
      oh_ff <= 1'b0;
      en_ff <= 12'h000;
      mon_ff <= 2'h3;
    end
    else
    begin
      ph_ff <= take;
      oh_ff <= oh_ff || (sample_tick && ev_cond[0]);
      if (done && c_ff)
        en_ff <= hwdata[14:3];
      if (done && m_ff)
        mon_ff <= hwdata[1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  one_wait_a: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("wait state count wrong");
  rd_hi_zero_a: assert property ($rose(hreadyout) && !w_ff |->
    hrdata[31:16] == 16'h0000) else $error("upper read bits not zero");
  ctrl_resv_a: assert property ($rose(hreadyout) && !w_ff && c_ff
    |-> hrdata[15] == 1'b0 && hrdata[1:0] == 2'h0)
    else $error("reserved control bits read nonzero");
  rd_hold_a: assert property (hreadyout && $past(hreadyout) |->
    $stable(hrdata)) else $error("read data moved while idle");
  reset_quiet_a: assert property ($rose(rst_b) |->
    hreadyout && alarm_out_b) else $error("outputs not idle after reset");
  mask_gate_a: assert property (!alarm_out_b |-> oh_ff ||
    (|en_ff) || (|$past(en_ff))) else $error("alarm low with no cause");
  overheat_pin_a: assert property (
    sample_tick && ev_cond[0] && mon_ff == 2'h3 |-> ##[1:2] !alarm_out_b)
    else $error("overheat did not pull the alarm low");
endmodule : mal_alarm_chk
bind mal_alarm_top mal_alarm_chk u_chk (.clk(clk), .rst_b(rst_b),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .sample_tick(sample_tick),
  .ev_cond(ev_cond), .alarm_out_b(alarm_out_b));

// >>> mal_alarm_top_test.sv
// Self-checking bench for the alarm mask and latch block.
module mal_alarm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CT = mal_pkg::CTRL_ADDR;
  localparam logic [31:0] ST = mal_pkg::STAT_ADDR;
  localparam logic [31:0] CF = mal_pkg::CFG_ADDR;
  localparam logic [31:0] MN = mal_pkg::MON_ADDR;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic sample_tick = 1'b0;
  logic [12:0] ev_cond = 13'h0;
  logic hreadyout, hresp, alarm_out_b, alarm_seen;
  logic [31:0] hrdata;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  mal_alarm_top dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sample_tick(sample_tick), .ev_cond(ev_cond),
    .alarm_out_b(alarm_out_b));
  mal_host_watch host (.clk(clk), .rst_b(rst_b), .alarm_out_b(alarm_out_b),
    .alarm_seen(alarm_seen));
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic [31:0] a, input logic w,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    hsize <= mal_pkg::HSIZE_WORD;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic smp(input logic [12:0] c);
    @(posedge clk);
    sample_tick <= 1'b1;
    ev_cond <= c;
    @(posedge clk);
    sample_tick <= 1'b0;
    ev_cond <= 13'h0;
  endtask : smp
  // The host sees the pin two edges after a flag, so three edges suffice.
  task automatic pin(input logic e);
    repeat (3) @(posedge clk);
    chk({31'h0, alarm_seen}, {31'h0, e});
  endtask : pin
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(CT, 32'h0);
    rd(CF, 32'h10);
    wr(CT, 32'hFFFFFFFF);
    rd(CT, 32'h7FFC);
    rd(32'h0, 32'h0);
    wr(CF, 32'h0);
    $display("registers done");
    for (int k = 1; k < 13; k++)
    begin
      wr(CT, 32'h7FF8 & ~(32'h1 << (k + 2)));
      smp(13'h1 << k);
      pin(1'b0);
      wr(CT, 32'h1 << (k + 2));
      pin(1'b1);
      rd(ST, 32'h1 << (k + 2));
      pin(1'b0);
    end
    $display("enable map done");
    wr(CT, 32'h0);
    smp(13'h1);
    pin(1'b1);
    rd(ST, 32'h4);
    $display("overheat done");
    wr(CT, 32'h200);
    for (int c = 0; c < 4; c++)
    begin
      wr(CF, {27'h0, c[1:0], 3'h0});
      // The previous pass left a saturated count; a clear sample drops it.
      smp(13'h0);
      // A clear sample in the middle must restart the count.
      for (int i = 0; i < 2 * (1 << c) - 1; i++)
        smp(i == (1 << c) - 1 ? 13'h0 : 13'h80);
      pin(1'b0);
      smp(13'h80);
      pin(1'b1);
      rd(ST, 32'h200);
    end
    $display("debounce done");
    wr(CF, 32'h0);
    wr(CT, 32'h0);
    smp(13'h1000);
    smp(13'h0);
    rd(ST, 32'h4000);
    rd(ST, 32'h0);
    smp(13'h1000);
    rd(ST, 32'h4000);
    smp(13'h1000);
    rd(ST, 32'h4000);
    wr(CT, 32'h4);
    smp(13'h1000);
    smp(13'h0);
    rd(ST, 32'h0);
    $display("latch modes done");
    wr(MN, 32'h1);
    smp(13'h181);
    rd(ST, 32'h0);
    wr(MN, 32'h3);
    wr(CT, 32'h0);
    smp(13'h1000);
    wr(MN, 32'h7);
    rd(ST, 32'h0);
    $display("sensor and soft reset done");
    summarize();
  end
endmodule : mal_alarm_top_test
